//--- hdl/bad_pkg.sv
package bad_pkg;
    // host memory bus widths
    localparam int ADDR_W            = 16;
    localparam int DATA_W            = 8;
    // top-of-space peripheral window
    localparam int IO_WIN_BITS       = 3;
    localparam logic [12:0] IO_WIN_TAG    = 13'h1fff;
    localparam logic [15:0] ADDR_PPI_A    = 16'hfff8;
    localparam logic [15:0] ADDR_PPI_CTL  = 16'hfffb;
    localparam logic [15:0] ADDR_OUT_LATCH = 16'hfffc;
    localparam logic [15:0] ADDR_SWITCHES = 16'hfffd;
    localparam logic [15:0] ADDR_RSVD_0   = 16'hfffe;
    localparam logic [15:0] ADDR_RSVD_1   = 16'hffff;
    // socket sizing: a15 splits halves, a14:a13 zero marks the 8k page
    localparam int HALF_BIT          = 15;
    localparam logic [1:0] PAGE_8K_TAG   = 2'h0;
    // shared output latch field positions
    localparam int LAT_PULLUP        = 0;
    localparam int LAT_LINE_DIR      = 1;
    localparam int LAT_BUZZER        = 2;
    localparam int LAT_ACTIVITY      = 3;
    localparam int LAT_GEN_LSB       = 4;
    localparam logic [7:0] LATCH_RESET   = 8'h00;
    localparam logic LINE_DIR_RX     = 1'b0;
    localparam logic LINE_DIR_TX     = 1'b1;

    // host bus sample, strobes active high after inversion
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              rd;
        logic              wr;
        logic              psen;
    } bad_bus_t;

    // strap levels
    typedef struct packed {
        logic type_rom;
        logic size_a;
        logic size_b;
    } bad_strap_t;

    // socket selects, active high
    typedef struct packed {
        logic program_rom;
        logic first_rw;
        logic second;
        logic ppi;
    } bad_sel_t;
endpackage

//--- hdl/bad_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin-level inputs
module bad_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output      logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;    // first stage, read only by second
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;    // second stage
    logic [WIDTH-1:0] sync_next;

    // next values: reset to a constant, else shift
    always_comb begin
        meta_next = rst ? RST_VAL : async_in;
        sync_next = rst ? RST_VAL : meta_reg;
    end

    // register both stages
    always_ff @(posedge core_clk) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg;
endmodule

//--- hdl/bad_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) line direction low receives, high transmits
// (R2) receiver stays enabled during transmit
// (R3) host may hold direction high point-to-point
// (R4) host raises direction only around sends
// (R5) code and data decoded as separate spaces
// (R6) peripherals always in top eight data bytes
// (R7) six peripheral addresses used, two reserved
// (R8) program socket selected for 32k code
// (R9) first rw socket 32k, skips peripherals
// (R10) second socket 8k or 32k, skips peripherals
// (R11) straps pick second socket size and type
// (R12) peripheral addresses fixed, never relocated
// (R13) serial memories take no decoded address
// (R14) latch readback shows all output settings
// (R15) parallel port registers at fff8..fffb
// (R16) shared output latch at fffc
// (R17) switch bank read-only at fffd
// (R18) output latch clears to zero on reset
// (R19) reserved addresses select nothing, ignore writes
module bad_decoder
    import bad_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] host_addr,
    input  wire logic [DATA_W-1:0] host_data_in,
    output      logic [DATA_W-1:0] host_data_out,
    output      logic              host_data_oe,
    input  wire logic              host_rd_n,
    input  wire logic              host_wr_n,
    input  wire logic              host_psen_n,
    input  wire logic              socket_type_strap,
    input  wire logic              socket_size_strap_a,
    input  wire logic              socket_size_strap_b,
    input  wire logic [DATA_W-1:0] config_switch_bank,
    output      logic              program_rom_socket_sel,
    output      logic              first_rw_memory_socket_sel,
    output      logic              second_memory_socket_sel,
    output      logic              ppi_sel,
    output      logic [1:0]        ppi_reg,
    output      logic              pullup_control,
    output      logic              line_direction,
    output      logic              line_receive_en,
    output      logic              buzzer_control,
    output      logic              activity_indicator,
    output      logic [3:0]        general_output_latch
);
    localparam int BUS_W = $bits(bad_bus_t);
    localparam logic [BUS_W-1:0] BUS_IDLE = '0;

    bad_bus_t          bus_raw;      // pin sample, strobes inverted
    bad_bus_t          bus_s;        // synchronised bus
    bad_bus_t          bus_prev_reg; // bus one cycle ago
    bad_bus_t          bus_prev_next;
    bad_strap_t        strap_s;      // synchronised straps
    logic [DATA_W-1:0] sw_s;         // synchronised switches
    bad_sel_t          sel_reg;      // registered selects
    bad_sel_t          sel_next;
    logic [1:0]        ppi_reg_reg;
    logic [1:0]        ppi_reg_next;
    logic [7:0]        latch_reg;    // shared output latch
    logic [7:0]        latch_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic              rdata_oe_reg;
    logic              rdata_oe_next;
    logic              second_32k;   // second socket decodes 32k
    logic              wr_end;       // write strobe just released

    // top eight bytes, tag compare is fixed wiring
    function automatic logic in_io(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:IO_WIN_BITS] == IO_WIN_TAG;         // [R6] [R12]
    endfunction

    // second socket page check for the chosen size
    function automatic logic in_second(input logic [ADDR_W-1:0] a,
                                       input logic big);
        return big || (a[14:13] == PAGE_8K_TAG);
    endfunction

    assign bus_raw = '{addr: host_addr, wdata: host_data_in,
                       rd: ~host_rd_n, wr: ~host_wr_n,
                       psen: ~host_psen_n};

    // everything from pins passes two flops before decode
    bad_sync #(.WIDTH(BUS_W), .RST_VAL(BUS_IDLE)) u_bus_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (bus_raw),
        .sync_out (bus_s)
    );

    // straps and switches share one synchroniser
    bad_sync #(.WIDTH(3 + DATA_W), .RST_VAL('0)) u_strap_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({socket_type_strap, socket_size_strap_a,
                    socket_size_strap_b, config_switch_bank}),
        .sync_out ({strap_s, sw_s})
    );

    // rom needs only strap b; rw 32k also needs strap a
    assign second_32k = strap_s.size_b
                        & (strap_s.type_rom | strap_s.size_a); // [R11]

    // latching on strobe release uses address and data still held
    assign wr_end = bus_prev_reg.wr & ~bus_s.wr;

    // select decode: code and data spaces kept apart
    always_comb begin
        sel_next     = '0;
        ppi_reg_next = bus_s.addr[1:0];
        // program socket: lower half of code space
        sel_next.program_rom = bus_s.psen
                               & ~bus_s.addr[HALF_BIT];            // [R5] [R8]
        // read-only second socket answers code fetches in upper half
        if (bus_s.psen && bus_s.addr[HALF_BIT] && strap_s.type_rom
            && in_second(bus_s.addr, second_32k)) begin
            sel_next.second = 1'b1;                               // [R11]
        end
        if (bus_s.rd || bus_s.wr) begin
            if (in_io(bus_s.addr)) begin
                // only fff8..fffb reach the parallel port
                sel_next.ppi = bus_s.addr[2] == 1'b0;             // [R15] [R7]
            end else if (bus_s.addr[HALF_BIT]) begin
                sel_next.first_rw = 1'b1;                         // [R9]
            end else if (in_second(bus_s.addr, second_32k)
                         && !(bus_s.wr && strap_s.type_rom)) begin
                sel_next.second = 1'b1;                           // [R10] [R11]
            end
        end
        // serial memories never appear here, they use port lines [R13]
        if (rst) begin
            sel_next     = '0;
            ppi_reg_next = 2'h0;
        end
    end

    // shared latch, readback and bus history
    always_comb begin
        bus_prev_next = rst ? bad_bus_t'(BUS_IDLE) : bus_s;
        latch_next    = latch_reg;
        rdata_next    = rdata_reg;
        rdata_oe_next = 1'b0;
        if (wr_end && bus_prev_reg.addr == ADDR_OUT_LATCH) begin
            latch_next = bus_prev_reg.wdata;                      // [R16]
        end
        // writes to switches or reserved bytes fall through [R17] [R19]
        if (bus_s.rd && bus_s.addr == ADDR_OUT_LATCH) begin
            rdata_next    = latch_reg;                            // [R14]
            rdata_oe_next = 1'b1;
        end else if (bus_s.rd && bus_s.addr == ADDR_SWITCHES) begin
            rdata_next    = sw_s;                                 // [R17]
            rdata_oe_next = 1'b1;
        end
        // reserved reads leave the bus undriven: harmless  [R19]
        if (rst) begin
            latch_next    = LATCH_RESET;                          // [R18]
            rdata_next    = '0;
            rdata_oe_next = 1'b0;
        end
    end

    // register all state
    always_ff @(posedge core_clk) begin
        bus_prev_reg <= bus_prev_next;
        sel_reg      <= sel_next;
        ppi_reg_reg  <= ppi_reg_next;
        latch_reg    <= latch_next;
        rdata_reg    <= rdata_next;
        rdata_oe_reg <= rdata_oe_next;
    end

    assign program_rom_socket_sel     = sel_reg.program_rom;
    assign first_rw_memory_socket_sel = sel_reg.first_rw;
    assign second_memory_socket_sel   = sel_reg.second;
    assign ppi_sel                    = sel_reg.ppi;
    assign ppi_reg                    = ppi_reg_reg;
    assign host_data_out              = rdata_reg;
    assign host_data_oe               = rdata_oe_reg;
    assign pullup_control             = latch_reg[LAT_PULLUP];
    assign line_direction             = latch_reg[LAT_LINE_DIR];  // [R1]
    // receiver never gated, so own characters echo back
    assign line_receive_en            = 1'b1;                     // [R2]
    assign buzzer_control             = latch_reg[LAT_BUZZER];
    assign activity_indicator         = latch_reg[LAT_ACTIVITY];
    assign general_output_latch       = latch_reg[7:LAT_GEN_LSB];

    // checks on decode, latch and readback
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_io_not_rw: assert property (                                 // [R9]
        $rose(bus_s.rd) && in_io(bus_s.addr) |=> !sel_reg.first_rw)
        else $error("first socket selected in io window");
    a_io_not_second: assert property (                             // [R10]
        (bus_s.rd || bus_s.wr) && in_io(bus_s.addr) |=> !sel_reg.second)
        else $error("second socket selected in io window");
    a_reserved_quiet: assert property (                            // [R19]
        bus_s.rd && (bus_s.addr == ADDR_RSVD_0
                     || bus_s.addr == ADDR_RSVD_1)
        |=> !sel_reg.ppi && !host_data_oe && !sel_reg.first_rw)
        else $error("reserved address selected something");
    a_ppi_range: assert property (                                 // [R15]
        bus_s.wr && bus_s.addr >= ADDR_PPI_A
        && bus_s.addr <= ADDR_PPI_CTL
        |=> sel_reg.ppi && ppi_reg == $past(bus_s.addr[1:0]))
        else $error("parallel port not selected");
    a_latch_write: assert property (                               // [R16]
        wr_end && bus_prev_reg.addr == ADDR_OUT_LATCH
        |=> general_output_latch == $past(bus_prev_reg.wdata[7:4],1)
            && line_direction == $past(bus_prev_reg.wdata[1],1))
        else $error("output latch not loaded");
    a_switch_ro: assert property (                                 // [R17]
        wr_end && bus_prev_reg.addr == ADDR_SWITCHES
        |=> $stable(latch_reg))
        else $error("switch address write changed latch");
    a_readback: assert property (                                  // [R14]
        bus_s.rd && bus_s.addr == ADDR_OUT_LATCH
        |=> host_data_oe && host_data_out == $past(latch_reg))
        else $error("latch readback wrong");
    a_rom_code: assert property (                                  // [R8]
        bus_s.psen |=> program_rom_socket_sel
                       == !$past(bus_s.addr[HALF_BIT]))
        else $error("program socket select wrong");
    a_rom_no_wr: assert property (                                 // [R11]
        bus_s.wr && strap_s.type_rom && !bus_s.addr[HALF_BIT]
        |=> !sel_reg.second)
        else $error("write reached read-only socket");
    a_rx_always: assert property (                                 // [R2]
        line_direction == LINE_DIR_TX |-> line_receive_en)
        else $error("receiver disabled while sending");
    a_latch_reset: assert property (@(posedge core_clk)            // [R18]
        disable iff (1'b0) rst |=> latch_reg == LATCH_RESET)
        else $error("latch not cleared by reset");

    c_latch_write: cover property (wr_end
        && bus_prev_reg.addr == ADDR_OUT_LATCH);
    c_switch_read: cover property (host_data_oe
        && bus_s.addr == ADDR_SWITCHES);
    c_second_8k: cover property (sel_reg.second && !second_32k);
    c_transmit: cover property (line_direction == LINE_DIR_TX);
endmodule

//--- testbench/bad_host_model.sv
`timescale 1ns/1ps
// host external bus model: one strobe at a time, held, then released
module bad_host_model
    import bad_pkg::*;
(
    input  wire logic              core_clk,
    output      logic [ADDR_W-1:0] host_addr,
    output      logic [DATA_W-1:0] host_data_in,
    output      logic              host_rd_n,
    output      logic              host_wr_n,
    output      logic              host_psen_n
);
    // idle bus from time zero
    initial begin
        host_addr = 16'h0000;
        host_data_in = 8'h00;
        host_rd_n = 1'b1;
        host_wr_n = 1'b1;
        host_psen_n = 1'b1;
    end

    // kind 0 read, 1 write, 2 code fetch; strobe held five cycles
    task automatic start(input int kind, input logic [15:0] a,
                         input logic [7:0] d);
        @(negedge core_clk);
        host_addr = a;
        if (kind == 1) begin
            host_data_in = d;
        end
        host_rd_n = (kind != 0);
        host_wr_n = (kind != 1);
        host_psen_n = (kind != 2);
        repeat (5) @(negedge core_clk);
    endtask

    // release; data kept two cycles for the latch, then scrambled so a
    // stale value can never pass for a held one
    task automatic finish();
        host_rd_n = 1'b1;
        host_wr_n = 1'b1;
        host_psen_n = 1'b1;
        repeat (2) @(negedge core_clk);
        host_data_in = ~host_data_in;
        repeat (3) @(negedge core_clk);
    endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
// self-checking bench for the board address decoder
module tb;
    import bad_pkg::*;
    logic              core_clk = 1'b0;   // 125 MHz
    logic              rst = 1'b1;        // synchronous, high
    logic [ADDR_W-1:0] host_addr;
    logic [DATA_W-1:0] host_data_in;
    logic [DATA_W-1:0] host_data_out;
    logic              host_data_oe;
    logic              host_rd_n;
    logic              host_wr_n;
    logic              host_psen_n;
    bad_strap_t        st = '0;           // strap levels
    logic [DATA_W-1:0] sw = 8'h3c;        // switch levels
    bad_sel_t          sel;               // observed selects
    logic [1:0]        ppi_reg;
    logic              pu, dir, rx_en, buzz, act;
    logic [3:0]        gen;
    int                err_count = 0;
    int                tests_run = 0;

    always #4 core_clk = ~core_clk;

    bad_host_model hm (.core_clk(core_clk), .host_addr(host_addr),
        .host_data_in(host_data_in), .host_rd_n(host_rd_n),
        .host_wr_n(host_wr_n), .host_psen_n(host_psen_n));

    bad_decoder uut (.core_clk(core_clk), .rst(rst),
        .host_addr(host_addr), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
        .host_psen_n(host_psen_n), .socket_type_strap(st.type_rom),
        .socket_size_strap_a(st.size_a), .socket_size_strap_b(st.size_b),
        .config_switch_bank(sw), .program_rom_socket_sel(sel.program_rom),
        .first_rw_memory_socket_sel(sel.first_rw),
        .second_memory_socket_sel(sel.second), .ppi_sel(sel.ppi),
        .ppi_reg(ppi_reg), .pullup_control(pu), .line_direction(dir),
        .line_receive_en(rx_en), .buzzer_control(buzz),
        .activity_indicator(act), .general_output_latch(gen));

    // compare a select set
    task automatic chk_sel(input string n, input bad_sel_t e);
        tests_run++;
        if (sel !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, sel);
        end
    endtask

    // compare a byte or narrower value
    task automatic chk_val(input string n, input logic [7:0] e,
                           input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // expected selects from the map; 8k page is a14:a13 zero
    function automatic bad_sel_t exp_sel(int k, logic [15:0] a);
        bad_sel_t e;
        logic     pg;
        e = '0;
        pg = (st.size_b & (st.type_rom | st.size_a)) | (a[14:13] == 2'h0);
        if (k == 2) begin
            e.program_rom = ~a[15];
            e.second = a[15] & st.type_rom & pg;
        end else if (a[15:3] == 13'h1fff) begin
            e.ppi = ~a[2];
        end else if (a[15]) begin
            e.first_rw = 1'b1;
        end else begin
            e.second = pg & ~(k == 1 & st.type_rom);
        end
        return e;
    endfunction

    // synchronous reset, three edges to flush synchronisers
    task automatic do_reset();
        @(negedge core_clk);
        rst = 1'b1;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask

    // one access; checks selects, output enable and read data as seen mid-strobe
    task automatic access(input int k, input logic [15:0] a,
                          input logic [7:0] d, input logic oe_e,
                          input logic [7:0] rd_e);
        hm.start(k, a, d);
        chk_sel("selects", exp_sel(k, a));
        chk_val("data_oe", {7'h0, oe_e}, {7'h0, host_data_oe});
        if (oe_e) begin
            chk_val("read_data", rd_e, host_data_out);
        end
        if (sel.ppi) begin
            chk_val("ppi_reg", {6'h0, a[1:0]}, {6'h0, ppi_reg});
        end
        hm.finish();
    endtask

    // latch outputs plus receiver enable
    task automatic chk_latch(input logic [7:0] e);
        chk_val("latch", e, {gen, act, buzz, dir, pu});
        chk_val("rx_en", 8'h01, {7'h0, rx_en});
    endtask

    // four strap sets, every kind, boundaries of each region
    task automatic t_decode();
        logic [15:0] al [12];
        al = '{16'h0000, 16'h1fff, 16'h2000, 16'h7fff, 16'h8000,
               16'h9fff, 16'ha000, 16'hfff7, 16'hfff8, 16'hfffb,
               16'hfffe, 16'hffff};
        foreach (al[i]) begin
            for (int s = 0; s < 4; s++) begin
                st = '{s[1], s[1] | s[0], s[0]};
                for (int k = 0; k < 3; k++) begin
                    access(k, al[i], al[i][7:0], 1'b0, 8'h00);
                end
            end
        end
    endtask

    // latch write, readback, direction, protected addresses, reset
    task automatic t_latch();
        chk_latch(8'h00);
        access(1, 16'hfffc, 8'ha6, 1'b0, 8'h00);
        chk_latch(8'ha6);
        access(0, 16'hfffc, 8'h00, 1'b1, 8'ha6);
        access(1, 16'hfffd, 8'hff, 1'b0, 8'h00);
        access(1, 16'hfffe, 8'hff, 1'b0, 8'h00);
        access(1, 16'hffff, 8'hff, 1'b0, 8'h00);
        chk_latch(8'ha6);
        access(0, 16'hfffd, 8'h00, 1'b1, 8'h3c);
        // a second switch pattern, so a stuck readback cannot pass
        sw = 8'ha5;
        access(0, 16'hfffd, 8'h00, 1'b1, 8'ha5);
        access(1, 16'hfffc, 8'h59, 1'b0, 8'h00);
        chk_latch(8'h59);
        access(0, 16'hfffc, 8'h00, 1'b1, 8'h59);
        access(1, 16'hfffc, 8'h02, 1'b0, 8'h00);
        chk_latch(8'h02);
        do_reset();
        chk_latch(8'h00);
        access(0, 16'hfffc, 8'h00, 1'b1, 8'h00);
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        do_reset();
        chk_sel("reset_sel", '0);
        t_latch();
        t_decode();
        complete_run();
    end

    // watchdog well past the expected run of about 1,700 cycles
    initial begin
        #200000;
        err_count++;
        complete_run();
    end
endmodule
